// file: hw/synth_ctl_pkg.sv
// constants for the synthesiser divider and lock control block
package synth_ctl_pkg;
  localparam logic [7:0] ADDR_DIV_DATA = 8'hB2;
  localparam logic [7:0] ADDR_CONTROL = 8'hB3;
  localparam logic [7:0] ADDR_STATUS = 8'hB4;
  localparam int N_WIDTH = 20;
  localparam int R_WIDTH = 13;
  localparam int NUM_SYNTH = 2;
  localparam int HIST_LEN = 3;
  localparam int TOL_NARROW = 1;
  localparam int TOL_WIDE = 4;
  // data word layout: [15:14] synth/set select, [13:12] word index, [11:0] payload
  localparam int DW_SYNTH = 15;
  localparam int DW_SET = 14;
  localparam int DW_IDX_HI = 13;
  localparam int DW_IDX_LO = 12;
  localparam int DW_PAY = 12;
  // control word layout per synth: base 0 or 8
  localparam int CTL_STRIDE = 8;
  localparam int CTL_EN = 0;
  localparam int CTL_PSAVE = 1;
  localparam int CTL_SETSEL = 2;
  localparam int CTL_GAIN = 3;
  localparam int CTL_TOL = 4;
  localparam int CTL_MASK = 5;
  localparam int CTL_REFSEL = 7;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
endpackage

// file: hw/rf_synth_divider_lock_control.sv
// synthesiser divider sets, pump gain select and lock detector
//
// Contract
// - output frequency equals reference times N divided by R.
// - two independent divider sets per synth, chosen by control register.
// - setup is four data writes; partial values stay, no interlock.
// - gain bit 3 or 11 selects high (1) or low (0) pump gain.
// - comparison frequency programmable from 2.5kHz up to 200kHz.
// - lock tolerance of one or four undivided reference cycles.
// - majority vote over last three lock measurements.
// - lock true only after two successive lock measurements.
// - lock bits readable in status register and maskable to interrupt.
// - lock means phase agreement only, no frequency check.
// - data and control 16-bit write-only, status 8-bit read-only.
// - N counter 20 bits, R counter 13 bits.
// - one control write swaps between transmit and receive sets.
// - locked to out-of-lock transition raises an interrupt.
// - one reference select, crystal or external, shared by both.
`timescale 1ns/100ps
`default_nettype none
module rf_synth_divider_lock_control
#(
  parameter int NW = synth_ctl_pkg::N_WIDTH,
  parameter int RW = synth_ctl_pkg::R_WIDTH
)
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // register port
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  // reference clocks and vco feedback, asynchronous pins
  input wire logic I_XTAL_REF,
  input wire logic I_EXTERNAL_SYNTH_REF_CLOCK,
  input wire logic [synth_ctl_pkg::NUM_SYNTH-1:0] I_VCO_FB,
  // phase comparator, pump gain and synth active outputs
  output logic [synth_ctl_pkg::NUM_SYNTH-1:0] O_PUMP_UP,
  output logic [synth_ctl_pkg::NUM_SYNTH-1:0] O_PUMP_DN,
  output logic [synth_ctl_pkg::NUM_SYNTH-1:0] O_PUMP_GAIN_HIGH,
  output logic [synth_ctl_pkg::NUM_SYNTH-1:0] O_SYNTH_ACTIVE
);
  import synth_ctl_pkg::*;

  // two data words per value, so wider dividers cannot be loaded
  if (NW < 1 || NW > 2 * DW_PAY || RW < 1 || RW > 2 * DW_PAY)
  begin : gen_bad_width
    $error("divider widths not supported");
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  // nval_r/rval_r index: synth*2 + set; tx set 0, rx set 1
  logic [NW-1:0] nval_r [4];
  logic [RW-1:0] rval_r [4];
  logic [NW-1:0] nval_nxt [4];
  logic [RW-1:0] rval_nxt [4];
  logic [15:0] ctl_r, ctl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [NUM_SYNTH-1:0] lock_r, lock_nxt;
  logic [NUM_SYNTH-1:0] irq_r, irq_nxt;

  always_comb
  begin
    logic [1:0] sel;
    logic [DW_PAY-1:0] pay;
    logic [2*DW_PAY-1:0] wide;
    sel = {I_WDATA[DW_SYNTH], I_WDATA[DW_SET]};
    pay = I_WDATA[DW_PAY-1:0];
    wide = '0;
    nval_nxt = nval_r;
    rval_nxt = rval_r;
    ctl_nxt = ctl_r;
    // write-only data: each write lands one 12-bit slice; no interlock
    if (I_WR && I_ADDR == ADDR_DIV_DATA)
    begin
      unique case (I_WDATA[DW_IDX_HI:DW_IDX_LO])
        2'h0:
        begin
          wide = {{DW_PAY{1'b0}}, pay} | ({2*DW_PAY{1'b0}} | 24'(nval_r[sel]) & 24'hFFF000);
          nval_nxt[sel] = NW'(wide);
        end
        2'h1:
        begin
          wide = {pay, {DW_PAY{1'b0}}} | (24'(nval_r[sel]) & 24'h000FFF);
          nval_nxt[sel] = NW'(wide);
        end
        2'h2:
        begin
          wide = {{DW_PAY{1'b0}}, pay} | (24'(rval_r[sel]) & 24'hFFF000);
          rval_nxt[sel] = RW'(wide);
        end
        default:
        begin
          wide = {pay, {DW_PAY{1'b0}}} | (24'(rval_r[sel]) & 24'h000FFF);
          rval_nxt[sel] = RW'(wide);
        end
      endcase
    end
    // one control write flips set select for either synth
    if (I_WR && I_ADDR == ADDR_CONTROL)
      ctl_nxt = I_WDATA;
  end

  // 8-bit read-only status: lock bits low, irq flags above
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (I_RD && I_ADDR == ADDR_STATUS)
      rdata_nxt = {4'h0, irq_r, lock_r};
    else if (I_RD)
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      for (int i = 0; i < 4; i++)
      begin
        nval_r[i] <= '0;
        rval_r[i] <= '0;
      end
      ctl_r <= CONTROL_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      nval_r <= nval_nxt;
      rval_r <= rval_nxt;
      ctl_r <= ctl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // clocks arrive as levels; edges are found after two flops
  logic [3:0] s1_r, s2_r, s3_r;
  logic ref_rise;
  logic [NUM_SYNTH-1:0] fb_rise;
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end
    else
    begin
      s1_r <= {I_VCO_FB, I_EXTERNAL_SYNTH_REF_CLOCK, I_XTAL_REF};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // shared reference select across both synths
  assign ref_rise = ctl_r[CTL_REFSEL] ? (s2_r[1] & ~s3_r[1]) : (s2_r[0] & ~s3_r[0]);
  assign fb_rise = s2_r[3:2] & ~s3_r[3:2];

  // ------------------------------------------------------------
  // per synth dividers, phase compare, lock detect
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SYNTH; g++)
    begin : gen_synth
      localparam int B = g * CTL_STRIDE;
      logic on, wide_tol;
      logic [1:0] idx;
      logic [RW-1:0] rcnt_r, rcnt_nxt;
      logic [NW-1:0] ncnt_r, ncnt_nxt;
      logic [2:0] tol_r, tol_nxt;
      logic up_r, up_nxt, dn_r, dn_nxt;
      logic meas_v, meas_ok;
      logic [HIST_LEN-1:0] hist_r, hist_nxt;
      logic [1:0] runs_r, runs_nxt;
      logic pref, pfb;
      assign on = ctl_r[B+CTL_EN] & ~ctl_r[B+CTL_PSAVE];
      assign wide_tol = ctl_r[B+CTL_TOL];
      assign idx = {1'(g), ctl_r[B+CTL_SETSEL]};
      // r counter divides the reference to the comparison rate
      assign pref = ref_rise && (rcnt_r <= RW'(1));
      assign pfb = fb_rise[g] && (ncnt_r <= NW'(1));
      always_comb
      begin
        rcnt_nxt = rcnt_r;
        ncnt_nxt = ncnt_r;
        up_nxt = up_r;
        dn_nxt = dn_r;
        tol_nxt = tol_r;
        meas_v = 1'b0;
        meas_ok = 1'b0;
        hist_nxt = hist_r;
        runs_nxt = runs_r;
        if (ref_rise)
          rcnt_nxt = pref ? rval_r[idx] : rcnt_r - RW'(1);
        if (fb_rise[g])
          ncnt_nxt = pfb ? nval_r[idx] : ncnt_r - NW'(1);
        // tolerance counted in undivided reference edges
        if ((up_r ^ dn_r) && ref_rise && tol_r != 3'h7)
          tol_nxt = tol_r + 3'h1;
        if (pref && pfb)
        begin
          meas_v = 1'b1;
          meas_ok = 1'b1;
        end
        else if (pref)
        begin
          if (dn_r)
          begin
            meas_v = 1'b1;
            dn_nxt = 1'b0;
          end
          else
            up_nxt = 1'b1;
        end
        else if (pfb)
        begin
          if (up_r)
          begin
            meas_v = 1'b1;
            up_nxt = 1'b0;
          end
          else
            dn_nxt = 1'b1;
        end
        if (meas_v && !meas_ok)
          // phase error only, frequency not judged
          meas_ok = (tol_r < 3'(wide_tol ? TOL_WIDE : TOL_NARROW));
        if (meas_v)
        begin
          tol_nxt = 3'h0;
          hist_nxt = {hist_r[HIST_LEN-2:0], meas_ok};
          runs_nxt = meas_ok ? (runs_r == 2'h3 ? runs_r : runs_r + 2'h1) : 2'h0;
        end
        if (!on)
        begin
          // stale history is dropped when not running
          rcnt_nxt = '0;
          ncnt_nxt = '0;
          up_nxt = 1'b0;
          dn_nxt = 1'b0;
          tol_nxt = 3'h0;
          hist_nxt = '0;
          runs_nxt = 2'h0;
        end
      end
      always_ff @(posedge I_REF_CLK)
      begin
        if (I_RESET)
        begin
          rcnt_r <= '0;
          ncnt_r <= '0;
          up_r <= 1'b0;
          dn_r <= 1'b0;
          tol_r <= 3'h0;
          hist_r <= '0;
          runs_r <= 2'h0;
        end
        else
        begin
          rcnt_r <= rcnt_nxt;
          ncnt_r <= ncnt_nxt;
          up_r <= up_nxt;
          dn_r <= dn_nxt;
          tol_r <= tol_nxt;
          hist_r <= hist_nxt;
          runs_r <= runs_nxt;
        end
      end
      // majority of three holds lock; first rise needs two good in a row
      assign lock_nxt[g] = on &&
        ((hist_nxt[0] & hist_nxt[1]) | (hist_nxt[1] & hist_nxt[2]) |
        (hist_nxt[0] & hist_nxt[2])) &&
        (lock_r[g] || runs_nxt >= 2'(HIST_LEN - 1));
      // loss of lock latches a flag; set wins over read clear
      assign irq_nxt[g] = (lock_r[g] & ~lock_nxt[g]) |
        (irq_r[g] & ~(I_RD && I_ADDR == ADDR_STATUS));
      assign O_PUMP_UP[g] = up_r;
      assign O_PUMP_DN[g] = dn_r;
      assign O_PUMP_GAIN_HIGH[g] = ctl_r[B+CTL_GAIN];
      assign O_SYNTH_ACTIVE[g] = on;
    end
  endgenerate

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      lock_r <= '0;
      irq_r <= '0;
    end
    else
    begin
      lock_r <= lock_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign O_RDATA = rdata_r;
  // each flag gated by its mask bit
  assign O_IRQ = (irq_r[0] & ctl_r[CTL_MASK]) | (irq_r[1] & ctl_r[CTL_STRIDE+CTL_MASK]);
endmodule
`default_nettype wire

// file: dv/synth_ctl_properties.sv
// port checker for the synthesiser control block
`timescale 1ns/100ps
`default_nettype none
module synth_ctl_properties
  import synth_ctl_pkg::*;
#(parameter int NW = N_WIDTH, parameter int RW = R_WIDTH)
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic [7:0] O_RDATA,
  input wire logic O_IRQ,
  input wire logic [NUM_SYNTH-1:0] O_PUMP_GAIN_HIGH,
  input wire logic [NUM_SYNTH-1:0] O_SYNTH_ACTIVE
);
  logic [1:0] mask_r;
  logic cw;
  assign cw = I_WR && I_ADDR == ADDR_CONTROL;
  // mirror of the mask bits, the irq output has no other visible cause
  always_ff @(posedge I_REF_CLK)
    if (I_RESET) mask_r <= 2'h0;
    else if (cw) mask_r <= {I_WDATA[13], I_WDATA[5]};
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  chk_gain_low: assert property (cw |=> O_PUMP_GAIN_HIGH[0] == $past(I_WDATA[3]))
    else $error("gain 0 wrong");
  chk_gain_high: assert property (cw |=> O_PUMP_GAIN_HIGH[1] == $past(I_WDATA[11]))
    else $error("gain 1 wrong");
  chk_active_state: assert property (cw |=> O_SYNTH_ACTIVE ==
    {$past(I_WDATA[8] & ~I_WDATA[9]), $past(I_WDATA[0] & ~I_WDATA[1])})
    else $error("active wrong");
  chk_read_other: assert property (I_RD && I_ADDR != ADDR_STATUS |=> O_RDATA == 8'h00)
    else $error("write-only read not zero");
  chk_read_hold: assert property (!I_RD |=> $stable(O_RDATA))
    else $error("read data moved");
  chk_read_top: assert property (I_RD |=> O_RDATA[7:4] == 4'h0)
    else $error("status upper bits set");
  chk_idle_lock: assert property (I_RD && I_ADDR == ADDR_STATUS && !O_SYNTH_ACTIVE[0]
    && $past(!O_SYNTH_ACTIVE[0]) |=> !O_RDATA[0]) else $error("idle synth locked");
  chk_irq_masked: assert property (mask_r == 2'h0 && $past(mask_r) == 2'h0
    && $past(mask_r, 2) == 2'h0 |-> !O_IRQ) else $error("masked irq raised");
endmodule
`default_nettype wire

// file: dv/host_model.sv
// host side of the register port
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  input wire logic [7:0] rdata
);
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // released lines show the inverse so stale values never look valid
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: dv/test_rf_synth_divider_lock_control.sv
// self-checking bench for the synthesiser control block
`timescale 1ns/100ps
`default_nettype none
module test_rf_synth_divider_lock_control;
  import synth_ctl_pkg::*;
  logic clk, rst, wr, rd, xtal, ext, irq;
  logic [7:0] addr, rdata, st;
  logic [15:0] wdata, c;
  logic [1:0] fb, up, dn, gain, act;
  logic [31:0] seed;
  int fails, total_checks, tick, half;
  rf_synth_divider_lock_control rf_synth_divider_lock_control_inst (.I_REF_CLK(clk),
    .I_RESET(rst), .I_WR(wr), .I_RD(rd), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
    .O_IRQ(irq), .I_XTAL_REF(xtal), .I_EXTERNAL_SYNTH_REF_CLOCK(ext), .I_VCO_FB(fb),
    .O_PUMP_UP(up), .O_PUMP_DN(dn), .O_PUMP_GAIN_HIGH(gain), .O_SYNTH_ACTIVE(act));
  host_model host_model_inst (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // external reference at a tenth of the clock; feedback 0 may run at half that
  always @(negedge clk)
  begin
    tick <= tick + 1;
    if (tick % 5 == 4) ext <= ~ext;
    if (tick % 5 == 4) fb[1] <= ~fb[1];
    if (tick % half == half - 1) fb[0] <= ~fb[0];
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] exp_pins(input logic [15:0] k);
    return {4'h0, k[11], k[3], k[8] & ~k[9], k[0] & ~k[1]};
  endfunction
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_st(input logic [7:0] want);
    st = 8'hFF;
    for (int n = 0; n < 1500 && st !== want; n++)
      host_model_inst.get(ADDR_STATUS, st);
    cmp8(st, want);
    if (st !== want)
      end_sim();
  endtask
  initial
  begin
    rst = 1'b1;
    xtal = 1'b0;
    ext = 1'b0;
    fb = 2'h0;
    tick = 0;
    half = 5;
    fails = 0;
    total_checks = 0;
    seed = 32'h0000002B;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    host_model_inst.get(ADDR_STATUS, st);
    cmp8(st, 8'h00);
    host_model_inst.get(ADDR_DIV_DATA, st);
    cmp8(st, 8'h00);
    host_model_inst.get(8'h5A, st);
    cmp8(st, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      c = seed[15:0];
      host_model_inst.put(ADDR_CONTROL, c);
      cmp8({4'h0, gain, act}, exp_pins(c));
    end
    host_model_inst.put(ADDR_CONTROL, 16'h0000);
    // both sets of both synths, four words each; tx divides by 4/4, rx by 8/4
    for (int k = 0; k < 16; k++)
    begin
      c[11:0] = (k % 4 == 0) ? ((k & 4) ? 12'h008 : 12'h004) : ((k % 4 == 2) ? 12'h004 : 12'h000);
      host_model_inst.put(ADDR_DIV_DATA, {k[3], k[2], k[1:0], c[11:0]});
    end
    host_model_inst.put(ADDR_CONTROL, 16'h31B5);
    host_model_inst.put(ADDR_CONTROL, 16'h31B1);
    wait_st(8'h03);
    half = 10;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(negedge clk);
    cmp8({7'h00, irq}, 8'h01);
    // slow feedback leaves the reference ahead, so the up pump must show
    for (int i = 0; i < 200 && up[0] !== 1'b1; i++)
      @(negedge clk);
    cmp8({7'h00, up[0]}, 8'h01);
    wait_st(8'h06);
    host_model_inst.get(ADDR_STATUS, st);
    cmp8(st, 8'h02);
    cmp8({7'h00, irq}, 8'h00);
    host_model_inst.put(ADDR_CONTROL, 16'h00B1);
    host_model_inst.get(ADDR_STATUS, st);
    cmp8(st & 8'h03, 8'h00);
    cmp8({6'h00, up[1], dn[1]}, 8'h00);
    end_sim();
  end
endmodule
bind rf_synth_divider_lock_control synth_ctl_properties #(.NW(NW), .RW(RW))
  synth_ctl_properties_inst (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_WR(I_WR),
  .I_RD(I_RD), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
  .O_PUMP_GAIN_HIGH(O_PUMP_GAIN_HIGH), .O_SYNTH_ACTIVE(O_SYNTH_ACTIVE));
`default_nettype wire
